/* File: shared/prog_mem_pkg.sv */
// Constants, enumerations and types shared by the program-memory read path
package prog_mem_pkg;

  // ----------------------------------------------------------------
  // Program store geometry
  // ----------------------------------------------------------------
  localparam int PC_W = 12;
  localparam int PROG_WORDS = 4096;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int PAGE_W = 8;
  localparam int PAGE_HI_W = PC_W - PAGE_W;
  localparam logic [PC_W-1:0] RESET_VECTOR = 12'h000;
  localparam logic [PAGE_HI_W-1:0] LAST_PAGE_HIGH = 4'hf;

  // ----------------------------------------------------------------
  // Data memory addressing
  // ----------------------------------------------------------------
  localparam int DMEM_AW = 10;
  localparam int SECTOR_LSB = 8;
  localparam int SECTOR_W = DMEM_AW - SECTOR_LSB;
  localparam logic [SECTOR_W-1:0] SECTOR0 = 2'h0;

  // ----------------------------------------------------------------
  // Status register bit positions and decimal adjust constants
  // ----------------------------------------------------------------
  localparam int ST_C = 0;
  localparam int ST_AC = 1;
  localparam int ST_Z = 2;
  localparam int ST_OV = 3;
  localparam logic [3:0] BCD_LIMIT = 4'h9;
  localparam logic [BYTE_W-1:0] BCD_FIX_LO = 8'h06;
  localparam logic [BYTE_W-1:0] BCD_FIX_HI = 8'h60;

  // ----------------------------------------------------------------
  // Serial link framing
  // ----------------------------------------------------------------
  localparam int PROG_HDR_BITS = 1 + PC_W;
  localparam int DBG_FRAME_BITS = 1 + PC_W;
  localparam int CNT_W = 6;

  // ----------------------------------------------------------------
  // Commands and operations
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_DAA,
    ALU_AND, ALU_OR, ALU_XOR, ALU_CPL,
    ALU_RR, ALU_RRC, ALU_RL, ALU_RLC,
    ALU_INC, ALU_DEC,
    ALU_SZ, ALU_SNZ, ALU_SIZ, ALU_SDZ
  } alu_op_t;

  typedef enum logic [2:0] {
    CMD_NONE, CMD_ALU, CMD_PCL_WRITE,
    CMD_TBL_RD, CMD_TBL_RD_INC, CMD_TBL_RD_LAST, CMD_TBL_RD_INC_LAST
  } cmd_t;

endpackage

/* File: shared/alu_if.sv */
// Carrier between the read path and its arithmetic unit
`timescale 1ns/100ps
interface alu_if;
  prog_mem_pkg::alu_op_t op;
  logic [prog_mem_pkg::BYTE_W-1:0] a;
  logic [prog_mem_pkg::BYTE_W-1:0] b;
  logic [prog_mem_pkg::BYTE_W-1:0] status_in;
  logic [prog_mem_pkg::BYTE_W-1:0] res;
  logic [prog_mem_pkg::BYTE_W-1:0] status_out;
  logic wr;
  logic skip;
  modport core (output op, output a, output b, output status_in,
                input res, input status_out, input wr, input skip);
  modport unit (input op, input a, input b, input status_in,
                output res, output status_out, output wr, output skip);
endinterface

/* File: hw/alu_unit.sv */
// Combinational arithmetic and logic unit
`timescale 1ns/100ps
module alu_unit (
  alu_if.unit u
);
  localparam int BW = prog_mem_pkg::BYTE_W;
  logic [BW:0] sum;
  logic [4:0] half;
  logic [BW-1:0] y;
  logic ci;
  logic sub_op;
  logic [BW-1:0] r;
  logic [BW-1:0] s;
  logic [BW:0] dadj;

  always_comb begin
    sub_op = (u.op == prog_mem_pkg::ALU_SUB) || (u.op == prog_mem_pkg::ALU_SBC);
    y = sub_op ? ~u.b : u.b;
    case (u.op)
      prog_mem_pkg::ALU_ADC, prog_mem_pkg::ALU_SBC: ci = u.status_in[prog_mem_pkg::ST_C];
      prog_mem_pkg::ALU_SUB: ci = 1'b1;
      default: ci = 1'b0;
    endcase
    sum = {1'b0, u.a} + {1'b0, y} + {{BW{1'b0}}, ci};
    half = {1'b0, u.a[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
    dadj = {1'b0, u.b};
    if (u.b[3:0] > prog_mem_pkg::BCD_LIMIT || u.status_in[prog_mem_pkg::ST_AC]) begin
      dadj = dadj + {1'b0, prog_mem_pkg::BCD_FIX_LO};
    end
    if (dadj[BW-1:4] > prog_mem_pkg::BCD_LIMIT || u.status_in[prog_mem_pkg::ST_C] || dadj[BW]) begin
      dadj = dadj + {1'b0, prog_mem_pkg::BCD_FIX_HI};
    end
    s = u.status_in;
    r = u.b;
    u.wr = 1'b1;
    u.skip = 1'b0;
    case (u.op)
      prog_mem_pkg::ALU_ADD, prog_mem_pkg::ALU_ADC, prog_mem_pkg::ALU_SUB, prog_mem_pkg::ALU_SBC: begin
        r = sum[BW-1:0];
        s[prog_mem_pkg::ST_C] = sum[BW];
        s[prog_mem_pkg::ST_AC] = half[4];
        s[prog_mem_pkg::ST_OV] = (u.a[BW-1] == y[BW-1]) && (r[BW-1] != u.a[BW-1]);
      end
      prog_mem_pkg::ALU_DAA: begin
        r = dadj[BW-1:0];
        s[prog_mem_pkg::ST_C] = dadj[BW] | u.status_in[prog_mem_pkg::ST_C];
      end
      prog_mem_pkg::ALU_AND: r = u.a & u.b;
      prog_mem_pkg::ALU_OR: r = u.a | u.b;
      prog_mem_pkg::ALU_XOR: r = u.a ^ u.b;
      prog_mem_pkg::ALU_CPL: r = ~u.b;
      prog_mem_pkg::ALU_RR: r = {u.b[0], u.b[BW-1:1]};
      prog_mem_pkg::ALU_RL: r = {u.b[BW-2:0], u.b[BW-1]};
      prog_mem_pkg::ALU_RRC: begin
        r = {u.status_in[prog_mem_pkg::ST_C], u.b[BW-1:1]};
        s[prog_mem_pkg::ST_C] = u.b[0];
      end
      prog_mem_pkg::ALU_RLC: begin
        r = {u.b[BW-2:0], u.status_in[prog_mem_pkg::ST_C]};
        s[prog_mem_pkg::ST_C] = u.b[BW-1];
      end
      prog_mem_pkg::ALU_INC, prog_mem_pkg::ALU_SIZ: r = u.b + 8'h01;
      prog_mem_pkg::ALU_DEC, prog_mem_pkg::ALU_SDZ: r = u.b - 8'h01;
      default: begin
        u.wr = 1'b0;
      end
    endcase
    // Rotations keep Z; skip tests leave status alone
    if (u.op != prog_mem_pkg::ALU_RR && u.op != prog_mem_pkg::ALU_RL && u.op != prog_mem_pkg::ALU_RRC
        && u.op != prog_mem_pkg::ALU_RLC && u.op != prog_mem_pkg::ALU_SZ && u.op != prog_mem_pkg::ALU_SNZ
        && u.op != prog_mem_pkg::ALU_SIZ && u.op != prog_mem_pkg::ALU_SDZ) begin
      s[prog_mem_pkg::ST_Z] = (r == 8'h00);
    end
    case (u.op)
      prog_mem_pkg::ALU_SZ: u.skip = (u.b == 8'h00);
      prog_mem_pkg::ALU_SNZ: u.skip = (u.b != 8'h00);
      prog_mem_pkg::ALU_SIZ, prog_mem_pkg::ALU_SDZ: u.skip = (r == 8'h00);
      default: u.skip = 1'b0;
    endcase
    u.res = r;
    u.status_out = s;
  end
endmodule

/* File: hw/program_memory_table_read.sv */
// Program store, program counter, table read path and serial links
`timescale 1ns/100ps
module program_memory_table_read #(
  parameter int WORD_W = prog_mem_pkg::WORD_W
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RESET_N,
  input wire logic I_CLK_EN,
  input wire logic I_CMD_VALID,
  input wire prog_mem_pkg::cmd_t I_CMD,
  input wire prog_mem_pkg::alu_op_t I_ALU_OP,
  input wire logic I_EXT_FORM,
  input wire logic [prog_mem_pkg::DMEM_AW-1:0] I_DEST_ADDR,
  input wire logic [prog_mem_pkg::BYTE_W-1:0] I_OPERAND_A,
  input wire logic [prog_mem_pkg::BYTE_W-1:0] I_OPERAND_B,
  input wire logic [prog_mem_pkg::BYTE_W-1:0] I_STATUS,
  input wire logic [prog_mem_pkg::BYTE_W-1:0] I_TBL_PTR_LOW,
  input wire logic [prog_mem_pkg::BYTE_W-1:0] I_TBL_PTR_HIGH,
  input wire logic I_TABLE_HIGH_HOLDING_WE,
  input wire logic [prog_mem_pkg::BYTE_W-1:0] I_TABLE_HIGH_HOLDING_WDATA,
  input wire logic I_PROG_MODE,
  input wire logic I_PROG_SERIAL_CLOCK,
  input wire logic I_PROG_SERIAL_DATA,
  input wire logic I_DEBUG_SERIAL_CLOCK,
  input wire logic I_DEBUG_SERIAL_DATA,
  output logic [WORD_W-1:0] O_INSTR,
  output logic O_INSTR_VALID,
  output logic [prog_mem_pkg::PC_W-1:0] O_PC,
  output logic O_BUSY,
  output logic O_DMEM_WE,
  output logic [prog_mem_pkg::DMEM_AW-1:0] O_DMEM_ADDR,
  output logic [prog_mem_pkg::BYTE_W-1:0] O_DMEM_WDATA,
  output logic O_STATUS_WE,
  output logic [prog_mem_pkg::BYTE_W-1:0] O_STATUS,
  output logic [prog_mem_pkg::BYTE_W-1:0] O_TABLE_HIGH_HOLDING,
  output logic O_TBL_PTR_WE,
  output logic [prog_mem_pkg::BYTE_W-1:0] O_TBL_PTR_LOW,
  output logic [prog_mem_pkg::BYTE_W-1:0] O_TBL_PTR_HIGH,
  output logic O_CMD_REFUSED,
  output logic O_PROG_SERIAL_DATA,
  output logic O_PROG_SERIAL_DATA_OE,
  output logic O_DEBUG_SERIAL_DATA,
  output logic O_DEBUG_SERIAL_DATA_OE
);
  localparam int PC_W = prog_mem_pkg::PC_W;
  localparam int BW = prog_mem_pkg::BYTE_W;
  localparam int PW = prog_mem_pkg::PAGE_W;
  localparam int HI_BITS = WORD_W - BW;
  localparam int PROG_FRAME_BITS = prog_mem_pkg::PROG_HDR_BITS + WORD_W;
  localparam int CW = prog_mem_pkg::CNT_W;

  typedef enum logic [1:0] {
    ST_RUN, ST_TBL_ADDR, ST_TBL_DATA
  } state_t;

  // ----------------------------------------------------------------
  // Storage and state
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] prog_mem [prog_mem_pkg::PROG_WORDS];
  state_t state_q;
  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] tbl_addr_q;
  logic [prog_mem_pkg::DMEM_AW-1:0] tbl_dest_q;
  logic tbl_inc_q;
  logic tbl_last_q;
  logic [BW-1:0] ptr_lo_q;
  logic [BW-1:0] ptr_hi_q;
  logic [WORD_W-1:0] tbl_word;
  logic [2*BW-1:0] ptr_inc;
  logic is_tbl;
  logic tbl_last;
  logic tbl_allowed;
  logic accept;

  alu_if alu_bus ();

  alu_unit u_alu (
    .u(alu_bus)
  );

  assign alu_bus.op = I_ALU_OP;
  assign alu_bus.a = I_OPERAND_A;
  assign alu_bus.b = I_OPERAND_B;
  assign alu_bus.status_in = I_STATUS;

  always_comb begin
    tbl_last = (I_CMD == prog_mem_pkg::CMD_TBL_RD_LAST) || (I_CMD == prog_mem_pkg::CMD_TBL_RD_INC_LAST);
    is_tbl = (I_CMD == prog_mem_pkg::CMD_TBL_RD) || (I_CMD == prog_mem_pkg::CMD_TBL_RD_INC)
             || tbl_last;
    // Short forms only reach sector 0; the extended form reaches any sector
    tbl_allowed = I_EXT_FORM || (I_DEST_ADDR[prog_mem_pkg::DMEM_AW-1:prog_mem_pkg::SECTOR_LSB]
                                 == prog_mem_pkg::SECTOR0);
    accept = I_CLK_EN && I_CMD_VALID && (state_q == ST_RUN) && !I_PROG_MODE;
    tbl_word = prog_mem[tbl_addr_q];
    ptr_inc = {ptr_hi_q, ptr_lo_q} + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Sequencer, program counter and instruction fetch
  // ----------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state_q <= ST_RUN;
      pc_q <= prog_mem_pkg::RESET_VECTOR;
      O_PC <= prog_mem_pkg::RESET_VECTOR;
      O_INSTR <= '0;
      O_INSTR_VALID <= 1'b0;
      O_BUSY <= 1'b0;
    end else if (I_CLK_EN) begin
      if (I_PROG_MODE) begin
        // Programming restarts execution at the reset location
        state_q <= ST_RUN;
        pc_q <= prog_mem_pkg::RESET_VECTOR;
        O_PC <= prog_mem_pkg::RESET_VECTOR;
        O_INSTR_VALID <= 1'b0;
        O_BUSY <= 1'b0;
      end else begin
        case (state_q)
          ST_RUN: begin
            if (accept && I_CMD == prog_mem_pkg::CMD_PCL_WRITE) begin
              pc_q <= {pc_q[PC_W-1:PW], I_OPERAND_B};
              O_PC <= {pc_q[PC_W-1:PW], I_OPERAND_B};
              O_INSTR_VALID <= 1'b0;
            end else if (accept && is_tbl && tbl_allowed) begin
              // Fetch is held so the presented instruction is kept for after the table cycle
              state_q <= ST_TBL_ADDR;
              O_INSTR_VALID <= 1'b0;
              O_BUSY <= 1'b1;
            end else begin
              O_INSTR <= prog_mem[pc_q];
              O_INSTR_VALID <= !(accept && I_CMD == prog_mem_pkg::CMD_ALU && alu_bus.skip);
              pc_q <= pc_q + 12'h001;
              O_PC <= pc_q + 12'h001;
            end
          end
          ST_TBL_ADDR: begin
            state_q <= ST_TBL_DATA;
          end
          ST_TBL_DATA: begin
            state_q <= ST_RUN;
            O_INSTR_VALID <= 1'b1;
            O_BUSY <= 1'b0;
          end
          default: begin
            state_q <= ST_RUN;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Table address capture
  // ----------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      tbl_addr_q <= '0;
      tbl_dest_q <= '0;
      tbl_inc_q <= 1'b0;
      tbl_last_q <= 1'b0;
      ptr_lo_q <= '0;
      ptr_hi_q <= '0;
    end else if (accept && is_tbl && tbl_allowed) begin
      if (tbl_last) begin
        tbl_addr_q <= {prog_mem_pkg::LAST_PAGE_HIGH, I_TBL_PTR_LOW};
      end else begin
        tbl_addr_q <= {I_TBL_PTR_HIGH[prog_mem_pkg::PAGE_HI_W-1:0], I_TBL_PTR_LOW};
      end
      tbl_dest_q <= I_DEST_ADDR;
      tbl_inc_q <= (I_CMD == prog_mem_pkg::CMD_TBL_RD_INC) || (I_CMD == prog_mem_pkg::CMD_TBL_RD_INC_LAST);
      tbl_last_q <= tbl_last;
      ptr_lo_q <= I_TBL_PTR_LOW;
      ptr_hi_q <= I_TBL_PTR_HIGH;
    end
  end

  // ----------------------------------------------------------------
  // Data register, status and pointer write-back
  // ----------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_DMEM_WE <= 1'b0;
      O_DMEM_ADDR <= '0;
      O_DMEM_WDATA <= '0;
      O_STATUS_WE <= 1'b0;
      O_STATUS <= '0;
      O_TBL_PTR_WE <= 1'b0;
      O_TBL_PTR_LOW <= '0;
      O_TBL_PTR_HIGH <= '0;
      O_CMD_REFUSED <= 1'b0;
    end else if (I_CLK_EN) begin
      O_DMEM_WE <= 1'b0;
      O_STATUS_WE <= 1'b0;
      O_TBL_PTR_WE <= 1'b0;
      O_CMD_REFUSED <= accept && is_tbl && !tbl_allowed;
      if (state_q == ST_TBL_DATA) begin
        O_DMEM_WE <= 1'b1;
        O_DMEM_ADDR <= tbl_dest_q;
        O_DMEM_WDATA <= tbl_word[BW-1:0];
        if (tbl_inc_q) begin
          O_TBL_PTR_WE <= 1'b1;
          O_TBL_PTR_LOW <= ptr_inc[BW-1:0];
          // The last-page pointer never carries into the high pointer
          O_TBL_PTR_HIGH <= tbl_last_q ? ptr_hi_q : ptr_inc[2*BW-1:BW];
        end
      end else if (accept && I_CMD == prog_mem_pkg::CMD_ALU) begin
        O_DMEM_WE <= alu_bus.wr;
        O_DMEM_ADDR <= I_DEST_ADDR;
        O_DMEM_WDATA <= alu_bus.res;
        O_STATUS_WE <= 1'b1;
        O_STATUS <= alu_bus.status_out;
      end
    end
  end

  // ----------------------------------------------------------------
  // Table-high holding register
  // ----------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_TABLE_HIGH_HOLDING <= '0;
    end else if (I_CLK_EN) begin
      if (state_q == ST_TBL_DATA) begin
        O_TABLE_HIGH_HOLDING <= BW'(tbl_word[WORD_W-1:BW]);
      end else if (I_TABLE_HIGH_HOLDING_WE) begin
        O_TABLE_HIGH_HOLDING <= I_TABLE_HIGH_HOLDING_WDATA;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial programming link
  // ----------------------------------------------------------------
  logic prog_clk_prev_q;
  logic [CW-1:0] prog_cnt_q;
  logic prog_read_q;
  logic [PC_W-1:0] prog_addr_q;
  logic [WORD_W-1:0] prog_shift_q;
  logic prog_rise;

  assign prog_rise = I_PROG_SERIAL_CLOCK && !prog_clk_prev_q;

  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      prog_clk_prev_q <= 1'b0;
      prog_cnt_q <= '0;
      prog_read_q <= 1'b0;
      prog_addr_q <= '0;
      prog_shift_q <= '0;
      O_PROG_SERIAL_DATA <= 1'b0;
      O_PROG_SERIAL_DATA_OE <= 1'b0;
    end else if (I_CLK_EN) begin
      prog_clk_prev_q <= I_PROG_SERIAL_CLOCK;
      if (!I_PROG_MODE) begin
        prog_cnt_q <= '0;
        O_PROG_SERIAL_DATA_OE <= 1'b0;
      end else if (prog_rise) begin
        prog_cnt_q <= (prog_cnt_q == CW'(PROG_FRAME_BITS - 1)) ? '0 : prog_cnt_q + 6'h01;
        if (prog_cnt_q == '0) begin
          prog_read_q <= I_PROG_SERIAL_DATA;
        end else if (prog_cnt_q < CW'(prog_mem_pkg::PROG_HDR_BITS)) begin
          prog_addr_q <= {prog_addr_q[PC_W-2:0], I_PROG_SERIAL_DATA};
        end else if (prog_read_q) begin
          // Device answers on the same line, most significant bit first
          if (prog_cnt_q == CW'(prog_mem_pkg::PROG_HDR_BITS)) begin
            O_PROG_SERIAL_DATA <= prog_mem[prog_addr_q][WORD_W-1];
            prog_shift_q <= {prog_mem[prog_addr_q][WORD_W-2:0], 1'b0};
          end else begin
            O_PROG_SERIAL_DATA <= prog_shift_q[WORD_W-1];
            prog_shift_q <= {prog_shift_q[WORD_W-2:0], 1'b0};
          end
        end else begin
          prog_shift_q <= {prog_shift_q[WORD_W-2:0], I_PROG_SERIAL_DATA};
        end
        O_PROG_SERIAL_DATA_OE <= prog_read_q && prog_cnt_q >= CW'(prog_mem_pkg::PROG_HDR_BITS)
                                 && prog_cnt_q != CW'(PROG_FRAME_BITS - 1);
      end
    end
  end

  // Storage has no reset: it models nonvolatile contents
  always_ff @(posedge I_SYS_CLK) begin
    if (I_CLK_EN && I_PROG_MODE && prog_rise && !prog_read_q
        && prog_cnt_q == CW'(PROG_FRAME_BITS - 1)) begin
      prog_mem[prog_addr_q] <= {prog_shift_q[WORD_W-2:0], I_PROG_SERIAL_DATA};
    end
  end

  // ----------------------------------------------------------------
  // Debug link: a request bit from the tool returns the program counter
  // ----------------------------------------------------------------
  logic dbg_clk_prev_q;
  logic [CW-1:0] dbg_cnt_q;
  logic [PC_W-1:0] dbg_shift_q;

  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      dbg_clk_prev_q <= 1'b0;
      dbg_cnt_q <= '0;
      dbg_shift_q <= '0;
      O_DEBUG_SERIAL_DATA <= 1'b0;
      O_DEBUG_SERIAL_DATA_OE <= 1'b0;
    end else if (I_CLK_EN) begin
      dbg_clk_prev_q <= I_DEBUG_SERIAL_CLOCK;
      if (I_DEBUG_SERIAL_CLOCK && !dbg_clk_prev_q) begin
        if (dbg_cnt_q == '0) begin
          if (I_DEBUG_SERIAL_DATA) begin
            dbg_cnt_q <= 6'h01;
            dbg_shift_q <= pc_q;
          end
          O_DEBUG_SERIAL_DATA_OE <= 1'b0;
        end else begin
          dbg_cnt_q <= (dbg_cnt_q == CW'(prog_mem_pkg::DBG_FRAME_BITS - 1)) ? '0 : dbg_cnt_q + 6'h01;
          O_DEBUG_SERIAL_DATA <= dbg_shift_q[PC_W-1];
          O_DEBUG_SERIAL_DATA_OE <= 1'b1;
          dbg_shift_q <= {dbg_shift_q[PC_W-2:0], 1'b0};
        end
      end else if (dbg_cnt_q == '0 && dbg_clk_prev_q && !I_DEBUG_SERIAL_CLOCK) begin
        O_DEBUG_SERIAL_DATA_OE <= 1'b0;
      end
    end
  end
endmodule

/* File: tb/prog_mem_monitor.sv */
// Concurrent checks on the program-memory read path ports
`timescale 1ns/100ps
module prog_mem_monitor #(
  parameter int WORD_W = 16
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RESET_N,
  input wire logic I_CLK_EN,
  input wire logic I_CMD_VALID,
  input wire prog_mem_pkg::cmd_t I_CMD,
  input wire logic I_EXT_FORM,
  input wire logic I_PROG_MODE,
  input wire logic [9:0] I_DEST_ADDR,
  input wire logic [7:0] I_OPERAND_B,
  input wire logic [11:0] O_PC,
  input wire logic O_INSTR_VALID,
  input wire logic O_BUSY,
  input wire logic O_DMEM_WE,
  input wire logic O_STATUS_WE,
  input wire logic O_CMD_REFUSED,
  input wire logic [7:0] O_TABLE_HIGH_HOLDING
);
  logic go, tbl, far;
  logic [3:0] page;
  assign go = I_CLK_EN && I_CMD_VALID && !O_BUSY && !I_PROG_MODE;
  assign tbl = go && I_CMD >= prog_mem_pkg::CMD_TBL_RD;
  assign far = I_DEST_ADDR[9:8] != 2'h0;
  assign page = O_PC[11:8];
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESET_N);
  a_reset_pc_zero: assert property (disable iff (1'b0) !I_RESET_N |=> O_PC == 12'h000)
    else $error("pc not zero after reset");
  a_tbl_start: assert property (tbl && (I_EXT_FORM || !far) |=> O_BUSY && !O_INSTR_VALID)
    else $error("table read did not start");
  a_busy_two_cyc: assert property ($rose(O_BUSY) |-> ##1 O_BUSY ##1 !O_BUSY)
    else $error("table read length wrong");
  a_busy_pc_hold: assert property (O_BUSY |-> !O_INSTR_VALID && $stable(O_PC))
    else $error("fetch during table read");
  a_tbl_done: assert property ($fell(O_BUSY) |-> O_DMEM_WE && O_INSTR_VALID)
    else $error("table end without write");
  a_high_zero: assert property ($fell(O_BUSY) |-> (O_TABLE_HIGH_HOLDING >> (WORD_W - 8)) == 8'h00)
    else $error("unused high bits set");
  a_short_refused: assert property (tbl && !I_EXT_FORM && far |=> O_CMD_REFUSED && !O_BUSY && !O_DMEM_WE)
    else $error("short form not refused");
  a_alu_status: assert property (go && I_CMD == prog_mem_pkg::CMD_ALU |=> O_STATUS_WE)
    else $error("no status write");
  a_pcl_jump: assert property (go && I_CMD == prog_mem_pkg::CMD_PCL_WRITE |=>
    O_PC == {$past(page), $past(I_OPERAND_B)} && !O_INSTR_VALID) else $error("bad in-page jump");
  c_table: cover property ($fell(O_BUSY));
  c_refuse: cover property (O_CMD_REFUSED);
  c_jump: cover property (go && I_CMD == prog_mem_pkg::CMD_PCL_WRITE);
endmodule
bind program_memory_table_read prog_mem_monitor #(.WORD_W(WORD_W)) u_mon (.I_SYS_CLK, .I_RESET_N,
  .I_CLK_EN, .I_CMD_VALID, .I_CMD, .I_EXT_FORM, .I_PROG_MODE, .I_DEST_ADDR, .I_OPERAND_B, .O_PC,
  .O_INSTR_VALID, .O_BUSY, .O_DMEM_WE, .O_STATUS_WE, .O_CMD_REFUSED, .O_TABLE_HIGH_HOLDING);

/* File: tb/core_model.sv */
// Behavioural core and serial programmer facing the read path
`timescale 1ns/100ps
module core_model #(parameter int DW = 16) (
  input wire logic i_clk,
  output logic o_valid,
  output prog_mem_pkg::cmd_t o_cmd,
  output prog_mem_pkg::alu_op_t o_op,
  output logic o_ext,
  output logic [9:0] o_dest,
  output logic [7:0] o_a,
  output logic [7:0] o_b,
  output logic [7:0] o_st,
  output logic [7:0] o_lo,
  output logic [7:0] o_hi,
  output logic o_pmode,
  output logic o_pclk,
  output logic o_pdata
);
  initial begin
    {o_valid, o_ext, o_dest, o_a, o_b, o_st, o_lo, o_hi, o_pmode, o_pclk, o_pdata} = '0;
    o_cmd = prog_mem_pkg::CMD_NONE;
    o_op = prog_mem_pkg::ALU_ADD;
  end
  // Entered just after an edge; gap idle cycles model a slow core
  task automatic issue(input prog_mem_pkg::cmd_t c, input int op, ext, d, a, b, st, lo, hi, gap);
    repeat (gap) begin
      @(posedge i_clk);
      #1;
    end
    o_cmd = c;
    o_op = prog_mem_pkg::alu_op_t'(op);
    {o_ext, o_dest, o_a, o_b, o_st} = {1'(ext), 10'(d), 8'(a), 8'(b), 8'(st)};
    {o_lo, o_hi} = {8'(lo), 8'(hi)};
    o_valid = 1'b1;
    @(posedge i_clk);
    #1;
    o_valid = 1'b0;
    // Pointers stay as core registers; operands are garbage once taken
    {o_a, o_b} = ~{o_a, o_b};
  endtask
  // Write frame, MSB first; serial clock stands low between frames
  task automatic prog_write(input logic [11:0] adr, input logic [15:0] dat, input logic last);
    logic [12+DW:0] bits;
    bits = {1'b0, adr, dat[DW-1:0]};
    o_pmode = 1'b1;
    for (int i = 12 + DW; i >= 0; i--) begin
      o_pdata = bits[i];
      repeat (2) @(posedge i_clk);
      #1;
      o_pclk = 1'b1;
      repeat (2) @(posedge i_clk);
      #1;
      o_pclk = 1'b0;
    end
    o_pdata = ~o_pdata;
    o_pmode = !last;
  endtask
endmodule

/* File: tb/program_memory_table_read_tb_top.sv */
// Self-checking bench for the program-memory read path
`timescale 1ns/100ps
module program_memory_table_read_tb_top;
  localparam int WW = 12;
  logic clk, rst_n, clk_en, hh_we, valid, ext, pmode, pclk, pdata, iv, busy, dwe, swe, pwe, refd;
  logic [7:0] hh_wd, a, b, st, lo, hi, dwd, sout, hh, plo, phi;
  logic [9:0] dest, daddr;
  logic [11:0] pc;
  logic [WW-1:0] instr;
  prog_mem_pkg::cmd_t cmd;
  prog_mem_pkg::alu_op_t op;
  int miscompares, num_checks;
  int mem[int];
  core_model #(.DW(WW)) u_core (.i_clk(clk), .o_valid(valid), .o_cmd(cmd), .o_op(op), .o_ext(ext), .o_dest(dest),
    .o_a(a), .o_b(b), .o_st(st), .o_lo(lo), .o_hi(hi), .o_pmode(pmode), .o_pclk(pclk), .o_pdata(pdata));
  program_memory_table_read #(.WORD_W(WW)) dut (.I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_CLK_EN(clk_en),
    .I_CMD_VALID(valid), .I_CMD(cmd), .I_ALU_OP(op), .I_EXT_FORM(ext), .I_DEST_ADDR(dest), .I_OPERAND_A(a),
    .I_OPERAND_B(b), .I_STATUS(st), .I_TBL_PTR_LOW(lo), .I_TBL_PTR_HIGH(hi), .I_TABLE_HIGH_HOLDING_WE(hh_we),
    .I_TABLE_HIGH_HOLDING_WDATA(hh_wd), .I_PROG_MODE(pmode), .I_PROG_SERIAL_CLOCK(pclk),
    .I_PROG_SERIAL_DATA(pdata), .I_DEBUG_SERIAL_CLOCK(1'b0), .I_DEBUG_SERIAL_DATA(1'b0), .O_INSTR(instr),
    .O_INSTR_VALID(iv), .O_PC(pc), .O_BUSY(busy), .O_DMEM_WE(dwe), .O_DMEM_ADDR(daddr), .O_DMEM_WDATA(dwd),
    .O_STATUS_WE(swe), .O_STATUS(sout), .O_TABLE_HIGH_HOLDING(hh), .O_TBL_PTR_WE(pwe), .O_TBL_PTR_LOW(plo),
    .O_TBL_PTR_HIGH(phi), .O_CMD_REFUSED(refd), .O_PROG_SERIAL_DATA(), .O_PROG_SERIAL_DATA_OE(),
    .O_DEBUG_SERIAL_DATA(), .O_DEBUG_SERIAL_DATA_OE());
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (!ok) begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Bit 8 of the result carries the expected carry; -1 means value not modelled
  function automatic int alu_ref(input int k, x, y, c);
    case (k)
      0: return x + y;
      1: return x + y + c;
      2: return x + 256 - y;
      3: return x + 255 + c - y;
      5: return x & y;
      6: return x | y;
      7: return x ^ y;
      8: return 255 - y;
      9: return y >> 1 | (y & 1) << 7;
      10: return y >> 1 | c << 7 | (y & 1) << 8;
      11: return y << 1 & 255 | y >> 7;
      12: return y << 1 | c;
      13: return (y + 1) & 255;
      14: return (y + 255) & 255;
      default: return -1;
    endcase
  endfunction
  task automatic tbl(input prog_mem_pkg::cmd_t c, input int ext, d, adr, hi);
    int w, nx, n;
    w = mem[adr] & ((1 << WW) - 1);
    nx = c >= prog_mem_pkg::CMD_TBL_RD_LAST ? hi << 8 | (adr + 1) & 255 : (hi << 8 | adr & 255) + 1;
    u_core.issue(c, 0, ext, d, 0, 0, 0, adr & 255, hi, 1);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (busy !== 1'b0 && n < 8);
    if (n >= 8) begin
      chk(1'b0, "table read hang");
      give_verdict();
    end
    chk(n == 2, "table cycles");
    chk(dwe === 1'b1 && daddr === 10'(d) && dwd === 8'(w), "table low byte");
    chk(hh === 8'(w >> 8), "table high byte");
    chk(pwe === 1'(c == prog_mem_pkg::CMD_TBL_RD_INC || c == prog_mem_pkg::CMD_TBL_RD_INC_LAST), "ptr we");
    if (pwe === 1'b1) chk({phi, plo} === 16'(nx), "pointer step");
  endtask
  initial begin
    int r, k, x, y, c, e, adr;
    int nrm[3], lst[3];
    r = $urandom(59435);
    {rst_n, clk_en, hh_we, hh_wd, miscompares, num_checks} = '0;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    clk_en = 1'b1;
    nrm = '{$urandom_range(1, 14) << 8 | 255, $urandom_range(1, 3839), $urandom_range(1, 3839)};
    lst = '{4095, 3846, 3840 + $urandom_range(0, 255)};
    for (k = 0; k < 7; k++) begin
      adr = k == 0 ? 0 : k < 4 ? nrm[k - 1] : lst[k - 4];
      mem[adr] = $urandom & 65535;
      u_core.prog_write(12'(adr), 16'(mem[adr]), k == 6);
    end
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(pc === 12'h000 && iv === 1'b0, "pc in reset");
    rst_n = 1'b1;
    @(posedge clk);
    #1;
    chk(instr === WW'(mem[0]) && iv === 1'b1 && pc === 12'h001, "reset vector fetch");
    for (k = 0; k < 8; k++) begin
      adr = k > 3 ? lst[k % 3] : nrm[k % 3];
      r = $urandom_range(0, 255);
      tbl(prog_mem_pkg::cmd_t'(prog_mem_pkg::CMD_TBL_RD + k / 2), k % 2, k % 2 ? $urandom_range(256, 1023) : r,
        adr, k > 3 ? r : r & 240 | adr >> 8);
    end
    u_core.issue(prog_mem_pkg::CMD_TBL_RD, 0, 0, $urandom_range(256, 1023), 0, 0, 0, 6, 15, 1);
    chk(refd === 1'b1 && busy === 1'b0 && dwe === 1'b0, "short form refused");
    for (k = 0; k < 19; k++) begin
      {x, y, c, adr} = {$urandom_range(0, 255), $urandom_range(0, 255), $urandom_range(0, 1), $urandom_range(0, 1023)};
      if (k > 14) y = k % 2 ? 0 : 1;
      e = alu_ref(k, x, y, c);
      u_core.issue(prog_mem_pkg::CMD_ALU, k, 0, adr, x, y, c, 0, 0, 1 + k % 2);
      chk(swe === 1'b1, "status write");
      chk(iv === 1'(k == 15 ? y != 0 : k == 16 ? y == 0 : k == 17 ? y != 255 : k == 18 ? y != 1 : 1), "skip");
      if (e >= 0) chk(dwe === 1'b1 && daddr === 10'(adr) && dwd === 8'(e), "alu result");
      if (k < 4 || k == 10 || k == 12) chk(sout[0] === e[8], "carry flag");
      if (k < 9 && k != 4 || k == 13 || k == 14) chk(sout[2] === (8'(e) == 8'h00), "zero flag");
    end
    y = $urandom_range(0, 255);
    u_core.issue(prog_mem_pkg::CMD_PCL_WRITE, 0, 0, 0, 0, y, 0, 0, 0, 1);
    chk(pc[7:0] === 8'(y) && iv === 1'b0, "in-page jump");
    clk_en = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(pc[7:0] === 8'(y) && iv === 1'b0, "clock enable freeze");
    clk_en = 1'b1;
    hh_wd = 8'($urandom_range(0, 15));
    hh_we = 1'b1;
    @(posedge clk);
    #1;
    hh_we = 1'b0;
    chk(hh === hh_wd, "holding write");
    give_verdict();
  end
endmodule
